// *** rim_pkg.sv ***
package rim_pkg;

  // ******************************************************
  // register offsets
  // ******************************************************
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0d;
  localparam logic [7:0] ADDR_COL_POS = 8'h0e;
  localparam logic [7:0] ADDR_STRENGTH = 8'h0f;
  localparam logic [7:0] ADDR_SPECIAL = 8'h10;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [5:0] MASK_RESET = 6'h3e;
  localparam logic [9:0] COL_POS_RESET = 10'h000;
  localparam logic [5:0] SPECIAL_RESET = 6'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ******************************************************
  // interrupt mask fields
  // ******************************************************
  localparam int MASK_COLLISION_POS_BIT9_BIT = 7;
  localparam int MASK_COLLISION_POS_BIT8_BIT = 6;
  localparam int MASK_EN_MSB = 5;

  // ******************************************************
  // strength register fields
  // ******************************************************
  localparam int STR_OSC_BIT = 6;
  localparam int STR_AUX_LSB = 3;
  localparam int STR_MAIN_LSB = 0;
  localparam int STR_W = 3;

  // ******************************************************
  // special function fields
  // ******************************************************
  localparam int SF_PARITY_OFF = 5;
  localparam int SF_SLOT_LONG = 4;
  localparam int SF_RAW_TX = 3;
  localparam int SF_FOUR_BIT_RX = 2;
  localparam int SF_NORMAL_FRAME = 1;
  localparam int SF_COL_SIX = 0;

  // ******************************************************
  // anticollision commands
  // ******************************************************
  localparam logic [7:0] CMD_SEL_CL1 = 8'h93;
  localparam logic [7:0] CMD_SEL_CL2 = 8'h95;
  localparam logic [7:0] CMD_SEL_CL3 = 8'h97;

  // ******************************************************
  // collision pulse thresholds
  // ******************************************************
  localparam logic [3:0] COL_THR_SEVEN = 4'h7;
  localparam logic [3:0] COL_THR_SIX = 4'h6;
  localparam logic [3:0] COL_CNT_MAX = 4'hf;

  // ******************************************************
  // timing
  // ******************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_STABLE_NS = 200000;
  localparam int OSC_STABLE_CYC = OSC_STABLE_NS / CLK_PERIOD_NS;
  localparam int SLOT_SHORT_NS = 18880;
  localparam int SLOT_LONG_NS = 37770;
  localparam int SLOT_SHORT_CYC =
    (SLOT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_LONG_CYC =
    (SLOT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_W = 11;
  localparam int OSC_CNT_W = 16;

endpackage

// *** rim_peak_latch.sv ***
module rim_peak_latch (
  input wire logic clk_i,         // device clock
  input wire logic clear_i,       // synchronous clear, high
  input wire logic sample_i,      // sample strobe, high
  input wire logic [2:0] level_i, // instantaneous level code
  output logic [2:0] peak_o       // held peak code
);

  logic [2:0] peak_r;
  logic [2:0] peak_nxt;

  // ******************************************************
  // peak hold
  // ******************************************************
  always_comb begin
    peak_nxt = peak_r;
    if (clear_i) begin
      peak_nxt = 3'h0;
    end else if (sample_i && (level_i > peak_r)) begin
      peak_nxt = level_i;
    end
  end

  always_ff @(posedge clk_i) begin
    peak_r <= peak_nxt;
  end

  assign peak_o = peak_r;

endmodule

// *** rim_regs.sv ***
// How it works
// - mask resets to 3e, also enable low
// - upper collision bits clear after mask read
// - mask bits 7,6 hold position bits 9,8
// - enables: fifo,crc,parity,framing,collision,noresponse
// - position byte resets zero, clears on read
// - non type a: position reports error bit
// - strength valid from receive to transmit
// - oscillator stable flag after 200 us
// - aux channel from second input, swappable
// - main strength in bits 2 to 0
// - strength latches peak of envelope
// - strength cleared at next transmit start
// - 3-bit code, seven 4 dB steps
// - amplitude command measures carrier on main channel, aux stays on inputs
// - bit 5 disables type a parity check
// - bit 4 selects long slot grid
// - bit 3 feeds raw bits to encoder
// - bit 2 selects 4-bit receive
// - bit 1 low: broken-byte anticollision framing
// - bit 0 picks 7 or 6 pulses
// - status read clears flags and irq line
// - collision flag when pulses exceed threshold
module rim_regs #(
  parameter int OSC_STABLE_CYCLES = rim_pkg::OSC_STABLE_CYC
) (
  input wire logic clk_i,               // device clock 40 mhz
  input wire logic rstn_i,              // sync reset, low
  input wire logic chip_en_i,           // chip enable, low = defaults
  input wire logic [7:0] addr_i,        // register address
  input wire logic wr_en_i,             // write strobe
  input wire logic rd_en_i,             // read strobe
  input wire logic [7:0] wdata_i,       // write data
  output logic [7:0] rdata_o,           // read data, registered
  input wire logic [5:0] irq_status_i,  // status bits 5..0
  output logic irq_o,                   // interrupt request
  input wire logic type_a_i,            // type a protocol active
  input wire logic col_valid_i,         // collision position strobe
  input wire logic err_valid_i,         // error position strobe
  input wire logic [9:0] pos_i,         // bit position
  input wire logic rx_active_i,         // reception in progress
  input wire logic tx_start_i,          // transmit start pulse
  input wire logic chan_swap_i,         // input swap select
  input wire logic [2:0] primary_receive_input_i,   // level on input 1
  input wire logic [2:0] secondary_receive_input_i, // level on input 2
  input wire logic amp_meas_i,          // carrier amplitude command
  input wire logic [2:0] carrier_level_i, // carrier amplitude code
  output logic osc_ok_o,                // oscillator stable
  output logic type_a_parity_off_o,     // parity check off
  output logic slot_grid_long_o,        // long slot grid
  output logic [10:0] slot_cycles_o,    // slot grid in cycles
  output logic type_a_raw_transmit_o,   // raw transmit mode
  input wire logic fifo_bit_i,          // bit from fifo path
  input wire logic raw_bit_i,           // bit from host stream
  output logic encoder_bit_o,           // bit to encoder
  output logic four_bit_rx_o,           // 4-bit receive mode
  input wire logic [7:0] cmd_byte_i,    // first command byte
  output logic broken_byte_frame_o,     // anticollision framing
  input wire logic subc_pulse_i,        // subcarrier pulse
  input wire logic bit_start_i,         // start of bit period
  output logic collision_det_o          // collision detected pulse
);

  // ******************************************************
  // declarations
  // ******************************************************
  logic clr;
  logic [5:0] mask_r;
  logic [5:0] mask_nxt;
  logic [9:0] pos_r;
  logic [9:0] pos_nxt;
  logic [5:0] sf_r;
  logic [5:0] sf_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [15:0] osc_cnt_r;
  logic [15:0] osc_cnt_nxt;
  logic osc_ok_r;
  logic osc_ok_nxt;
  logic [3:0] pcnt_r;
  logic [3:0] pcnt_nxt;
  logic col_det_r;
  logic col_det_nxt;
  logic [3:0] col_thr;
  logic [2:0] main_src;
  logic [2:0] aux_src;
  logic [2:0] main_peak;
  logic [2:0] aux_peak;
  logic str_clr;
  logic [7:0] strength;
  logic rd_mask;
  logic rd_pos;
  logic pos_load;

  assign clr = !rstn_i || !chip_en_i;
  assign rd_mask = rd_en_i && (addr_i == rim_pkg::ADDR_IRQ_MASK);
  assign rd_pos = rd_en_i && (addr_i == rim_pkg::ADDR_COL_POS);
  assign pos_load = col_valid_i || (err_valid_i && !type_a_i);

  // ******************************************************
  // interrupt mask and collision position
  // ******************************************************
  always_comb begin
    mask_nxt = mask_r;
    pos_nxt = pos_r;
    if (clr) begin
      mask_nxt = rim_pkg::MASK_RESET;
      pos_nxt = rim_pkg::COL_POS_RESET;
    end else begin
      if (wr_en_i && (addr_i == rim_pkg::ADDR_IRQ_MASK)) begin
        mask_nxt = wdata_i[rim_pkg::MASK_EN_MSB:0];
      end
      if (rd_mask) begin
        pos_nxt[9:8] = 2'h0;
      end
      if (rd_pos) begin
        pos_nxt[7:0] = 8'h00;
      end
      // a new position wins over a read clear
      if (pos_load) begin
        pos_nxt = pos_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    mask_r <= mask_nxt;
    pos_r <= pos_nxt;
  end

  // ******************************************************
  // special functions
  // ******************************************************
  always_comb begin
    sf_nxt = sf_r;
    if (clr) begin
      sf_nxt = rim_pkg::SPECIAL_RESET;
    end else if (wr_en_i && (addr_i == rim_pkg::ADDR_SPECIAL)) begin
      sf_nxt = wdata_i[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    sf_r <= sf_nxt;
  end

  assign type_a_parity_off_o = sf_r[rim_pkg::SF_PARITY_OFF];
  assign slot_grid_long_o = sf_r[rim_pkg::SF_SLOT_LONG];
  assign slot_cycles_o = sf_r[rim_pkg::SF_SLOT_LONG] ?
    11'(rim_pkg::SLOT_LONG_CYC) : 11'(rim_pkg::SLOT_SHORT_CYC);
  assign type_a_raw_transmit_o = sf_r[rim_pkg::SF_RAW_TX];
  assign encoder_bit_o = sf_r[rim_pkg::SF_RAW_TX] ?
    raw_bit_i : fifo_bit_i;
  assign four_bit_rx_o = sf_r[rim_pkg::SF_FOUR_BIT_RX];
  assign broken_byte_frame_o = !sf_r[rim_pkg::SF_NORMAL_FRAME] &&
    ((cmd_byte_i == rim_pkg::CMD_SEL_CL1) ||
     (cmd_byte_i == rim_pkg::CMD_SEL_CL2) ||
     (cmd_byte_i == rim_pkg::CMD_SEL_CL3));

  // ******************************************************
  // collision pulse counter
  // ******************************************************
  assign col_thr = sf_r[rim_pkg::SF_COL_SIX] ?
    rim_pkg::COL_THR_SIX : rim_pkg::COL_THR_SEVEN;

  always_comb begin
    pcnt_nxt = pcnt_r;
    col_det_nxt = 1'b0;
    if (clr || !type_a_i) begin
      pcnt_nxt = 4'h0;
    end else begin
      if (bit_start_i) begin
        pcnt_nxt = {3'h0, subc_pulse_i};
      end else if (subc_pulse_i && (pcnt_r != rim_pkg::COL_CNT_MAX)) begin
        pcnt_nxt = pcnt_r + 4'h1;
      end
      // one pulse per bit period, on crossing the threshold
      if (subc_pulse_i && !bit_start_i && (pcnt_r == col_thr)) begin
        col_det_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    pcnt_r <= pcnt_nxt;
    col_det_r <= col_det_nxt;
  end

  assign collision_det_o = col_det_r;

  // ******************************************************
  // signal strength
  // ******************************************************
  assign main_src = amp_meas_i ? carrier_level_i :
    (chan_swap_i ? secondary_receive_input_i
                 : primary_receive_input_i);
  assign aux_src = chan_swap_i ? primary_receive_input_i
                               : secondary_receive_input_i;
  assign str_clr = clr || tx_start_i;

  rim_peak_latch u_main_peak (
    .clk_i(clk_i),
    .clear_i(str_clr),
    .sample_i(rx_active_i || amp_meas_i),
    .level_i(main_src),
    .peak_o(main_peak)
  );

  rim_peak_latch u_aux_peak (
    .clk_i(clk_i),
    .clear_i(str_clr),
    .sample_i(rx_active_i),
    .level_i(aux_src),
    .peak_o(aux_peak)
  );

  // peaks hold until the next transmit start
  always_comb begin
    strength = 8'h00;
    strength[rim_pkg::STR_OSC_BIT] = osc_ok_r;
    strength[rim_pkg::STR_AUX_LSB +: rim_pkg::STR_W] = aux_peak;
    strength[rim_pkg::STR_MAIN_LSB +: rim_pkg::STR_W] = main_peak;
  end

  // ******************************************************
  // oscillator settle timer
  // ******************************************************
  always_comb begin
    osc_cnt_nxt = osc_cnt_r;
    osc_ok_nxt = osc_ok_r;
    if (clr) begin
      osc_cnt_nxt = 16'h0000;
      osc_ok_nxt = 1'b0;
    end else if (!osc_ok_r) begin
      if (osc_cnt_r == 16'(OSC_STABLE_CYCLES - 1)) begin
        osc_ok_nxt = 1'b1;
      end else begin
        osc_cnt_nxt = osc_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    osc_cnt_r <= osc_cnt_nxt;
    osc_ok_r <= osc_ok_nxt;
  end

  assign osc_ok_o = osc_ok_r;

  // ******************************************************
  // read port
  // ******************************************************
  always_comb begin
    rdata_nxt = rdata_r;
    if (clr) begin
      rdata_nxt = rim_pkg::RDATA_RESET;
    end else if (rd_en_i) begin
      unique case (addr_i)
        rim_pkg::ADDR_IRQ_MASK: begin
          rdata_nxt = {pos_r[9:8], mask_r};
        end
        rim_pkg::ADDR_COL_POS: begin
          rdata_nxt = pos_r[7:0];
        end
        rim_pkg::ADDR_STRENGTH: begin
          rdata_nxt = strength;
        end
        rim_pkg::ADDR_SPECIAL: begin
          rdata_nxt = {2'h0, sf_r};
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_r <= rdata_nxt;
  end

  assign rdata_o = rdata_r;

  // ******************************************************
  // interrupt request
  // ******************************************************
  // the status register outside drops its bits when read,
  // which releases this line one cycle later
  always_comb begin
    irq_nxt = 1'b0;
    if (!clr) begin
      irq_nxt = |(irq_status_i & mask_r);
    end
  end

  always_ff @(posedge clk_i) begin
    irq_r <= irq_nxt;
  end

  assign irq_o = irq_r;

endmodule

// *** rim_regs_properties.sv ***
module rim_regs_properties #(
  parameter int OSC_STABLE_CYCLES = rim_pkg::OSC_STABLE_CYC
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset
  input wire logic chip_en_i, // enable
  input wire logic [7:0] addr_i, // address
  input wire logic wr_en_i, // write
  input wire logic rd_en_i, // read
  input wire logic [7:0] wdata_i, // write data
  input wire logic [7:0] rdata_o, // read data
  input wire logic col_valid_i, // position load
  input wire logic err_valid_i, // position load
  input wire logic osc_ok_o, // oscillator ok
  input wire logic slot_grid_long_o, // slot grid
  input wire logic [10:0] slot_cycles_o, // slot cycles
  input wire logic type_a_raw_transmit_o, // raw mode
  input wire logic fifo_bit_i, // fifo bit
  input wire logic raw_bit_i, // raw bit
  input wire logic encoder_bit_o, // encoder bit
  input wire logic [7:0] cmd_byte_i, // command
  input wire logic broken_byte_frame_o // framing
);
  // ******************************************************
  // cycles since reset release
  // ******************************************************
  logic [31:0] up_r;
  logic [31:0] up_nxt;
  always_comb up_nxt = (rstn_i && chip_en_i) ? up_r + 32'd1 : 32'd0;
  always_ff @(posedge clk_i) up_r <= up_nxt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ******************************************************
  // assertions
  // ******************************************************
  enc_mux_a: assert property (
    encoder_bit_o == (type_a_raw_transmit_o ? raw_bit_i : fifo_bit_i))
    else $error("encoder bit from wrong source");
  slot_grid_a: assert property (
    slot_cycles_o == (slot_grid_long_o ? 11'd1511 : 11'd756))
    else $error("slot grid length wrong");
  frame_cmd_a: assert property (
    broken_byte_frame_o |-> cmd_byte_i inside {8'h93, 8'h95, 8'h97})
    else $error("broken byte framing on other command");
  unmapped_rd_a: assert property (
    rd_en_i && chip_en_i && (addr_i < 8'h0d || addr_i > 8'h10)
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  special_wr_a: assert property (
    wr_en_i && chip_en_i && addr_i == 8'h10
    |=> {slot_grid_long_o, type_a_raw_transmit_o} == $past(wdata_i[4:3]))
    else $error("special write not applied");
  pos_clr_a: assert property (
    rd_en_i && chip_en_i && addr_i == 8'h0e && !col_valid_i && !err_valid_i
    ##1 (!rd_en_i && chip_en_i && !col_valid_i && !err_valid_i) [*2]
    ##1 rd_en_i && chip_en_i && addr_i == 8'h0e && !col_valid_i
    && !err_valid_i |=> rdata_o == 8'h00)
    else $error("position byte not cleared by read");
  strength_rd_a: assert property (
    rd_en_i && chip_en_i && addr_i == 8'h0f
    |=> !rdata_o[7] && rdata_o[6] == $past(osc_ok_o))
    else $error("oscillator flag read wrong");
  reset_out_a: assert property (
    !chip_en_i |=> rdata_o == 8'h00 && !osc_ok_o)
    else $error("enable low did not reset outputs");
  osc_time_a: assert property (
    $rose(osc_ok_o) |-> up_r == OSC_STABLE_CYCLES)
    else $error("oscillator flag at wrong time");
endmodule

bind rim_regs rim_regs_properties #(
  .OSC_STABLE_CYCLES(OSC_STABLE_CYCLES)
) u_chk (.*);

// *** rim_host.sv ***
module rim_host (
  input wire logic clk_i, // clock
  output logic [7:0] addr_o, // address
  output logic wr_en_o, // write strobe
  output logic rd_en_o, // read strobe
  output logic [7:0] wdata_o, // write data
  input wire logic [7:0] rdata_i // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = 8'h00;
  end
  // ******************************************************
  // one access per call; lines scrambled when idle
  // ******************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    // read data stands from the edge after the strobe
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// *** rim_regs_bench.sv ***
module rim_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic chip_en_i = 1'b1;
  logic [7:0] addr_i, wdata_i, rdata_o, cmd_byte_i = 8'h00;
  logic wr_en_i, rd_en_i, irq_o, osc_ok_o, type_a_parity_off_o;
  logic slot_grid_long_o, type_a_raw_transmit_o, encoder_bit_o;
  logic four_bit_rx_o, broken_byte_frame_o, collision_det_o;
  logic [10:0] slot_cycles_o;
  wire [3:0] sf_bits = {type_a_parity_off_o, slot_grid_long_o,
    type_a_raw_transmit_o, four_bit_rx_o};
  logic [5:0] irq_status_i = 6'h00;
  logic [9:0] pos_i = 10'h2a5;
  logic [2:0] primary_receive_input_i = 3'h0;
  logic [2:0] secondary_receive_input_i = 3'h0;
  logic [2:0] carrier_level_i = 3'h4;
  logic type_a_i = 1'b1, rx_active_i = 1'b0, chan_swap_i = 1'b0;
  logic amp_meas_i = 1'b0, fifo_bit_i = 1'b0, raw_bit_i = 1'b1;
  logic [4:0] pz = 5'h00;
  wire col_valid_i = pz[0];
  wire err_valid_i = pz[1];
  wire tx_start_i = pz[2];
  wire subc_pulse_i = pz[3];
  wire bit_start_i = pz[4];
  int n_mismatch = 0;
  int n_tests = 0;
  int n_det = 0;
  int cyc = 0;

  rim_regs #(.OSC_STABLE_CYCLES(10)) u_dut (.*);
  rim_host u_host (.clk_i(clk_i), .addr_o(addr_i), .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .wdata_o(wdata_i), .rdata_i(rdata_o));

  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (collision_det_o === 1'b1) n_det <= n_det + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ******************************************************
  // helpers
  // ******************************************************
  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk("rdata", {8'h00, d}, {8'h00, e});
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    pz[k] <= 1'b1;
    @(posedge clk_i);
    pz[k] <= 1'b0;
  endtask
  task automatic coltest(input logic [7:0] sf, input int n, input int e);
    int d0;
    u_host.wr(8'h10, sf);
    d0 = n_det;
    pulse(4);
    repeat (n) pulse(3);
    repeat (3) @(posedge clk_i);
    chk("coldet", 16'(n_det - d0), 16'(e));
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rchk(8'h0f, 8'h00);
    rchk(8'h0d, 8'h3e);
    rchk(8'h0e, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h0f, 8'h40);
    u_host.wr(8'h0d, 8'hff);
    u_host.wr(8'h0e, 8'hff);
    rchk(8'h0d, 8'h3f);
    rchk(8'h0e, 8'h00);
    irq_status_i <= 6'h01;
    repeat (2) @(posedge clk_i);
    #1 chk("irq", irq_o, 1'b1);
    u_host.wr(8'h0d, 8'h3e);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", irq_o, 1'b0);
    @(posedge clk_i);
    irq_status_i <= 6'h02;
    repeat (2) @(posedge clk_i);
    #1 chk("irq", irq_o, 1'b1);
    @(posedge clk_i);
    // bench empties the status register directly, standing in for a host status read
    irq_status_i <= 6'h00;
    repeat (2) @(posedge clk_i);
    #1 chk("irq", irq_o, 1'b0);
    u_host.wr(8'h10, 8'hff);
    rchk(8'h10, 8'h3f);
    chk("sf", sf_bits, 4'hf);
    chk("slot", slot_cycles_o, 11'd1511);
    chk("enc", encoder_bit_o, 1'b1);
    u_host.wr(8'h10, 8'h00);
    #1 chk("slot", slot_cycles_o, 11'd756);
    chk("enc", encoder_bit_o, 1'b0);
    for (int c = 8'h93; c <= 8'h99; c += 2) begin
      @(posedge clk_i);
      cmd_byte_i <= 8'(c);
      @(posedge clk_i);
      #1 chk("frame", broken_byte_frame_o, c != 8'h99);
    end
    u_host.wr(8'h10, 8'h02);
    @(posedge clk_i);
    cmd_byte_i <= 8'h93;
    @(posedge clk_i);
    #1 chk("frame", broken_byte_frame_o, 1'b0);
    coltest(8'h00, 7, 0);
    coltest(8'h00, 8, 1);
    coltest(8'h01, 6, 0);
    coltest(8'h01, 7, 1);
    pulse(0);
    rchk(8'h0d, 8'hbe);
    rchk(8'h0d, 8'h3e);
    rchk(8'h0e, 8'ha5);
    rchk(8'h0e, 8'h00);
    type_a_i <= 1'b0;
    pos_i <= 10'h013;
    pulse(1);
    rchk(8'h0e, 8'h13);
    @(posedge clk_i);
    rx_active_i <= 1'b1;
    primary_receive_input_i <= 3'h3;
    secondary_receive_input_i <= 3'h5;
    @(posedge clk_i);
    primary_receive_input_i <= 3'h1;
    secondary_receive_input_i <= 3'h2;
    @(posedge clk_i);
    rx_active_i <= 1'b0;
    primary_receive_input_i <= 3'h7;
    rchk(8'h0f, 8'h6b);
    pulse(2);
    rchk(8'h0f, 8'h40);
    @(posedge clk_i);
    chan_swap_i <= 1'b1;
    rx_active_i <= 1'b1;
    primary_receive_input_i <= 3'h6;
    @(posedge clk_i);
    rx_active_i <= 1'b0;
    rchk(8'h0f, 8'h72);
    pulse(2);
    amp_meas_i <= 1'b1;
    rchk(8'h0f, 8'h44);
    u_host.wr(8'h0d, 8'h00);
    chip_en_i <= 1'b0;
    @(posedge clk_i);
    chip_en_i <= 1'b1;
    rchk(8'h0d, 8'h3e);
    test_done();
  end
endmodule
